// *** rtl/trip_monitor_pkg.sv ***
/*
 * Constants for the supply trip monitor: control bit positions, reset values
 * and the settle time of the reference after enable.
 * Assumes a 40 MHz system clock.
 */
package trip_monitor_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int LEVEL_W = 4;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam int CTRL_READY_BIT = 4;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_FALL_BIT = 0;
    localparam int CTRL_RISE_BIT = 1;
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_FLAG_BIT = 6;
    // Least settle time of the reference after enable, in ns
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC_RAW = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_SETTLE,
        ST_READY
    } mon_state_t;
endpackage : trip_monitor_pkg

// *** rtl/supply_trip_monitor.sv ***
/*
 * Control and event logic of the supply trip monitor.
 * Assumes an analog comparator (above trip level = 1) and a band gap ready
 * level, both asynchronous to clk, and software control bits on plain ports.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Software programs trip level and watch directions
// - Watched crossing sets the event flag
// - Interrupt only when flag and enable set
// - Enable toggling never causes an event
// - Ready status bit four, low after enable
// - Events suppressed unless enabled and ready
// - Rising watch detects below-to-above crossing
// - Falling watch detects above-to-below crossing
// - Both watches flag either crossing
// - Status bit reports supply above or below
// - Enable off powers detector down
module supply_trip_monitor #(
    parameter int SETTLE_CYCLES = trip_monitor_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic monitor_enable,
    input wire logic watch_rising,
    input wire logic watch_falling,
    input wire logic [trip_monitor_pkg::LEVEL_W-1:0] trip_level_select,
    input wire logic irq_enable,
    input wire logic flag_clear,
    input wire logic cmp_above,
    input wire logic ref_stable,
    output logic [trip_monitor_pkg::LEVEL_W-1:0] trip_level_out,
    output logic analog_enable,
    output logic [7:0] monitor_control_first,
    output logic event_flag,
    output logic status_above,
    output logic ref_ready,
    output logic irq
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    // Synchroniser stages for the analog inputs
    logic cmp_s1_q, cmp_s1_d;
    logic cmp_s2_q, cmp_s2_d;
    logic rdy_s1_q, rdy_s1_d;
    logic rdy_s2_q, rdy_s2_d;
    // Registered software controls
    logic [trip_monitor_pkg::LEVEL_W-1:0] level_q, level_d;
    logic en_q, en_d;
    // Reference settle sequencer
    trip_monitor_pkg::mon_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    // Crossing history and event
    logic prev_valid_q, prev_valid_d;
    logic prev_above_q, prev_above_d;
    logic crossing;
    logic flag_q, flag_d;
    logic irq_q, irq_d;
    // Status image
    logic above_q, above_d;
    logic [7:0] ctrl_q, ctrl_d;

    // Two flip-flops per analog input; logic reads only the second
    always_comb begin
        cmp_s1_d = cmp_above;
        cmp_s2_d = cmp_s1_q;
        rdy_s1_d = ref_stable;
        rdy_s2_d = rdy_s1_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= cmp_s1_d;
            cmp_s2_q <= cmp_s2_d;
            rdy_s1_q <= rdy_s1_d;
            rdy_s2_q <= rdy_s2_d;
        end
    end

    // Level and enable reach the analog side one cycle after software
    always_comb begin
        level_d = trip_level_select;
        en_d = monitor_enable;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            level_q <= trip_monitor_pkg::LEVEL_RESET;
            en_q <= 1'b0;
        end else begin
            level_q <= level_d;
            en_q <= en_d;
        end
    end

    // Ready needs the least settle count and a synchronised stable flag
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            trip_monitor_pkg::ST_OFF: begin
                cnt_d = '0;
                if (en_q) begin
                    state_d = trip_monitor_pkg::ST_SETTLE;
                end
            end
            trip_monitor_pkg::ST_SETTLE: begin
                if (!en_q) begin
                    state_d = trip_monitor_pkg::ST_OFF;
                end else if (cnt_q >= CW'(SETTLE_CYCLES - 1) && rdy_s2_q) begin
                    state_d = trip_monitor_pkg::ST_READY;
                end else if (cnt_q < CW'(SETTLE_CYCLES - 1)) begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            trip_monitor_pkg::ST_READY: begin
                if (!en_q) begin
                    state_d = trip_monitor_pkg::ST_OFF;
                end
            end
            default: state_d = trip_monitor_pkg::ST_OFF;
        endcase
        ready_d = (state_d == trip_monitor_pkg::ST_READY);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= trip_monitor_pkg::ST_OFF;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    // The first sample after ready only primes the history, so the
    // enable edge itself never looks like a crossing
    always_comb begin
        prev_valid_d = ready_q;
        prev_above_d = cmp_s2_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_valid_q <= 1'b0;
            prev_above_q <= 1'b0;
        end else begin
            prev_valid_q <= prev_valid_d;
            prev_above_q <= prev_above_d;
        end
    end

    // A crossing and a clear in one cycle leave the flag set
    always_comb begin
        crossing = ready_q && prev_valid_q && en_q &&
                   ((watch_rising && !prev_above_q && cmp_s2_q) ||
                    (watch_falling && prev_above_q && !cmp_s2_q));
        flag_d = flag_q;
        if (flag_clear) begin
            flag_d = 1'b0;
        end
        if (crossing) begin
            flag_d = 1'b1;
        end
        // Request follows the next flag value so both rise together
        irq_d = flag_d && irq_enable;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            irq_q <= irq_d;
        end
    end

    // Status byte: enable, flag, above, ready, watch bits; bits 3:2 read zero
    always_comb begin
        // Reads low while the monitor is off or not ready
        above_d = ready_q && en_q && cmp_s2_q;
        ctrl_d = 8'h00;
        ctrl_d[trip_monitor_pkg::CTRL_EN_BIT] = en_q;
        ctrl_d[trip_monitor_pkg::CTRL_FLAG_BIT] = flag_d;
        ctrl_d[trip_monitor_pkg::CTRL_OUT_BIT] = above_d;
        ctrl_d[trip_monitor_pkg::CTRL_READY_BIT] = ready_d;
        ctrl_d[trip_monitor_pkg::CTRL_RISE_BIT] = watch_rising;
        ctrl_d[trip_monitor_pkg::CTRL_FALL_BIT] = watch_falling;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            above_q <= 1'b0;
            ctrl_q <= 8'h00;
        end else begin
            above_q <= above_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Every output comes straight from a flip-flop
    assign trip_level_out = level_q;
    assign analog_enable = en_q;
    assign monitor_control_first = ctrl_q;
    assign event_flag = flag_q;
    assign status_above = above_q;
    assign ref_ready = ready_q;
    assign irq = irq_q;
endmodule : supply_trip_monitor
`default_nettype wire

// *** testbench/trip_monitor_properties.sv ***
/* Port checker of the supply trip monitor.
   Bound to every supply_trip_monitor instance; one clock, srst resets. */
`timescale 1ns/1ps
`default_nettype none
module trip_monitor_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic monitor_enable,
    input wire logic irq_enable,
    input wire logic flag_clear,
    input wire logic analog_enable,
    input wire logic [7:0] monitor_control_first,
    input wire logic event_flag,
    input wire logic status_above,
    input wire logic ref_ready,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence en_off_s;
        $fell(analog_enable);
    endsequence
    sequence flag_up_s;
        $rose(event_flag);
    endsequence
    rise_guard_a: assert property (flag_up_s |-> $past(ref_ready) && $past(analog_enable))
        else $error("event while not ready");
    above_off_a: assert property (!analog_enable |=> !status_above)
        else $error("above while off");
    en_follow_a: assert property (!$past(srst) |-> analog_enable == $past(monitor_enable))
        else $error("analog enable");
    irq_tie_a: assert property (irq == (event_flag && $past(irq_enable)))
        else $error("irq");
    ready_drop_a: assert property (en_off_s |=> !ref_ready)
        else $error("ready drop");
    ctrl_bits_a: assert property (monitor_control_first[6:4] == {event_flag, status_above, ref_ready})
        else $error("status bits");
    above_invalid_a: assert property (!ref_ready && !$past(ref_ready) |-> !status_above)
        else $error("above");
    flag_hold_a: assert property (event_flag && !flag_clear |=> event_flag)
        else $error("flag hold");
    clear_idle_a: assert property (flag_clear && !ref_ready |=> !event_flag)
        else $error("flag clear");
    no_event_off_a: assert property (!event_flag && !ref_ready |=> !event_flag)
        else $error("event off");
endmodule : trip_monitor_checker
bind supply_trip_monitor trip_monitor_checker u_chk (.clk, .srst, .monitor_enable, .irq_enable,
    .flag_clear, .analog_enable, .monitor_control_first, .event_flag, .status_above, .ref_ready,
    .irq);
`default_nettype wire

// *** testbench/analog_front_model.sv ***
/* Comparator and band gap model.
   Supply code comes from the bench; reference settles after enable. */
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    input wire logic clk,
    input wire logic analog_enable,
    input wire logic [3:0] trip_level_out,
    input wire logic [3:0] supply,
    output logic cmp_above,
    output logic ref_stable
);
    logic [2:0] wait_q = 3'h0;
    logic flip_q = 1'b0;
    always @(posedge clk) begin
        wait_q <= analog_enable ? wait_q + {2'h0, wait_q != 3'h7} : 3'h0;
        flip_q <= !flip_q;
    end
    assign ref_stable = (wait_q == 3'h7);
    // Powered down: output wanders
    assign cmp_above = analog_enable ? (supply > trip_level_out) : flip_q;
endmodule : analog_front_model
`default_nettype wire

// *** testbench/tb_top.sv ***
/* Self-checking bench of the supply trip monitor.
   Inputs change 2 ns after each rising edge. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, srst = 1'b1, en = 1'b0, rise = 1'b0, fall = 1'b0, ie = 1'b0, clr = 1'b0;
    logic [3:0] lvl = 4'h8, supply = 4'h4, lvl_out;
    logic cmp, stab, aen, flag, above, rdy, irq;
    logic [7:0] ctrl;
    int errors = 0, total_checks = 0;
    always #12.5 clk = !clk;
    supply_trip_monitor #(.SETTLE_CYCLES(2)) u_dut (.clk, .srst, .monitor_enable(en),
        .watch_rising(rise), .watch_falling(fall), .trip_level_select(lvl), .irq_enable(ie),
        .flag_clear(clr), .cmp_above(cmp), .ref_stable(stab), .trip_level_out(lvl_out),
        .analog_enable(aen), .monitor_control_first(ctrl), .event_flag(flag),
        .status_above(above), .ref_ready(rdy), .irq);
    analog_front_model u_front (.clk, .analog_enable(aen), .trip_level_out(lvl_out), .supply,
        .cmp_above(cmp), .ref_stable(stab));
    task step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task wait_ready;
        for (int i = 0; i < 50 && rdy !== 1'b1; i++) step(1);
        chk({7'h00, rdy}, 8'h01);
        if (rdy !== 1'b1) close_out();
    endtask : wait_ready
    initial begin
        step(8);
        srst = 1'b0;
        step(1);
        chk(ctrl, 8'h00);
        {en, rise, fall} = 3'b111;
        step(1);
        chk({7'h00, rdy}, 8'h00);
        wait_ready();
        step(3);
        chk({2'b00, flag, above, lvl_out}, 8'h08);
        chk(ctrl, 8'h93);
        for (int m = 1; m < 4; m++) begin
            {rise, fall, ie, clr} = {m[1], m[0], m[0], 1'b1};
            step(1);
            clr = 1'b0;
            supply = 4'hc;
            step(6);
            chk({6'h00, flag, above}, {6'h00, m[1], 1'b1});
            clr = (m == 3);
            step(1);
            clr = 1'b0;
            chk({7'h00, flag}, {7'h00, m[1] & !m[0]});
            supply = 4'h4;
            step(6);
            chk({6'h00, flag, irq}, {6'h00, 1'b1, m[0]});
        end
        clr = 1'b1;
        step(1);
        {clr, en, supply} = {2'b00, 4'hc};
        step(6);
        chk({4'h0, aen, rdy, flag, irq}, 8'h00);
        en = 1'b1;
        wait_ready();
        step(3);
        chk({6'h00, flag, above}, 8'h01);
        lvl = 4'hd;
        step(6);
        chk({4'h0, lvl_out}, 8'h0d);
        chk({6'h00, flag, above}, 8'h02);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
